// >>> hdl/drc_pkg.sv
package drc_pkg;
   // clock
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned CLK_NS = 40;
   // power-up
   localparam int unsigned POWERUP_US = 100;
   localparam int unsigned POWERUP_CYC = POWERUP_US * CLK_MHZ;
   localparam int unsigned INIT_ROW_CYCLES = 8;
   // refresh
   localparam int unsigned REFRESH_MS = 2;
   localparam int unsigned REFRESH_ROWS = 128;
   localparam int unsigned REFRESH_WINDOW_CYC = REFRESH_MS * 1000 * CLK_MHZ;
   localparam int unsigned REFRESH_GAP_CYC = REFRESH_WINDOW_CYC / REFRESH_ROWS;
   // strobe timing (ns)
   localparam int unsigned ROW_PRECHARGE_NS = 150;
   localparam int unsigned ROW_PULSE_NS = 200;
   localparam int unsigned ROW_TO_COLUMN_DELAY_NS = 30;
   localparam int unsigned COLUMN_PULSE_NS = 120;
   localparam int unsigned COLUMN_ACCESS_TIME_NS = 120;
   localparam int unsigned ROW_ACCESS_TIME_NS = 200;
   localparam int unsigned COLUMN_TO_WRITE_DELAY_NS = 80;
   localparam int unsigned ROW_TO_WRITE_DELAY_NS = 160;
   localparam int unsigned WRITE_PULSE_NS = 45;
   localparam int unsigned READ_HOLD_TO_COLUMN_RELEASE_NS = 0;
   function automatic int unsigned ns_up(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_up
   localparam int unsigned PRECHARGE_CYC = ns_up(ROW_PRECHARGE_NS);
   localparam int unsigned ROW_PULSE_CYC = ns_up(ROW_PULSE_NS);
   localparam int unsigned RCD_CYC = ns_up(ROW_TO_COLUMN_DELAY_NS);
   localparam int unsigned CAS_PULSE_CYC = ns_up(COLUMN_PULSE_NS);
   localparam int unsigned CAC_CYC = ns_up(COLUMN_ACCESS_TIME_NS);
   localparam int unsigned CWD_CYC = ns_up(COLUMN_TO_WRITE_DELAY_NS);
   localparam int unsigned RWD_CYC = ns_up(ROW_TO_WRITE_DELAY_NS);
   localparam int unsigned WP_CYC = ns_up(WRITE_PULSE_NS);
   // geometry
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned HALF_W = 7;
   // operations
   typedef enum logic [1:0] {
      DRC_OP_READ = 2'h0,
      DRC_OP_WRITE = 2'h1,
      DRC_OP_RMW = 2'h2
   } drc_op_t;
endpackage : drc_pkg

// >>> hdl/drc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage input synchroniser; change accepted once stages two and three agree
module drc_sync
   import drc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic agree;
   assign agree = (s2_q == s3_q);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) begin
            dout <= s3_q;
         end
      end
   end
endmodule : drc_sync
`default_nettype wire

// >>> hdl/drc_ctrl.sv
// Behaviour
// - after reset wait 100 us then issue eight row-strobe cycles before serving requests.
// - in a read the write line stays inactive until after both strobes are released.
// - write is never asserted between the early and delayed windows, so output is never undefined.
// - column strobe may rise during a row-only refresh without harm.
// - the 14-bit address is presented as row half then column half on seven lines.
// - all 128 rows are refreshed within each 2 ms window.
`timescale 1ns/10ps
`default_nettype none
module drc_ctrl
   import drc_pkg::*;
#(
   parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
   parameter int unsigned REFRESH_GAP = REFRESH_GAP_CYC,
   parameter bit HIDDEN_REFRESH = 1'b1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // user request
   input wire logic req_valid,
   output logic req_ready,
   input wire drc_op_t req_op,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_wdata,
   // user answer
   output logic rsp_valid,
   output logic rsp_rdata,
   output logic init_done,
   // memory pins
   output logic [HALF_W-1:0] mem_addr,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_write_n,
   output logic mem_din,
   input wire logic mem_dout
);
   typedef enum logic [8:0] {
      ST_POWERUP = 9'h001,
      ST_IDLE = 9'h002,
      ST_ROW = 9'h004,
      ST_COL = 9'h008,
      ST_WAIT = 9'h010,
      ST_WRITE = 9'h020,
      ST_RELEASE = 9'h040,
      ST_REFRESH = 9'h080,
      ST_PRECHARGE = 9'h100
   } drc_state_t;

   localparam int unsigned CNT_W = 24;
   localparam int unsigned SYNC_LAT = 4;

   drc_state_t state_q;
   drc_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] ref_timer_q;
   logic [3:0] init_cnt_q;
   logic init_done_q;
   logic ref_pending_q;
   logic [HALF_W-1:0] ref_row_q;
   drc_op_t op_q;
   logic [ADDR_W-1:0] addr_q;
   logic wdata_q;
   logic hidden_q;
   logic mem_dout_s;
   logic cnt_done;
   logic ref_tick;
   logic start_req;
   logic start_ref;
   logic write_op;
   logic hide_ref;
   logic [CNT_W-1:0] pwr_q;
   logic pwr_done_q;

   drc_sync u_sync (
      .clk(clk),
      .rst(rst),
      .din(mem_dout),
      .dout(mem_dout_s)
   );

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      return CNT_W'(n - 1);
   endfunction : cyc

   assign cnt_done = (cnt_q == '0);
   assign ref_tick = (ref_timer_q == '0);
   assign write_op = (op_q != DRC_OP_READ);
   assign start_ref = (state_q == ST_IDLE) && (ref_pending_q || !init_done_q);
   assign start_req = (state_q == ST_IDLE) && !start_ref && req_valid;
   // a read that ends with a refresh pending keeps column strobe low and refreshes under it
   assign hide_ref = HIDDEN_REFRESH && hidden_q && ref_pending_q;
   assign req_ready = start_req;
   assign init_done = init_done_q;

   // sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_POWERUP: if (pwr_done_q) state_d = ST_IDLE;
         ST_IDLE: begin
            if (start_ref) state_d = ST_REFRESH;
            else if (start_req) state_d = ST_ROW;
         end
         ST_ROW: if (cnt_done) state_d = ST_COL;
         ST_COL: state_d = ST_WAIT;
         ST_WAIT: begin
            if (cnt_done) state_d = (op_q == DRC_OP_READ) ? ST_RELEASE : ST_WRITE;
         end
         ST_WRITE: if (cnt_done) state_d = ST_RELEASE;
         ST_RELEASE: begin
            if (hide_ref) state_d = ST_REFRESH;
            else state_d = ST_PRECHARGE;
         end
         ST_REFRESH: if (cnt_done) state_d = ST_PRECHARGE;
         ST_PRECHARGE: if (cnt_done) state_d = ST_IDLE;
      endcase
   end

   // state and counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_POWERUP;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            unique case (state_d)
               ST_ROW: cnt_q <= cyc(RCD_CYC);
               ST_WAIT: begin
                  if (op_q == DRC_OP_READ) cnt_q <= cyc(CAC_CYC + SYNC_LAT);
                  else if (op_q == DRC_OP_RMW) cnt_q <= cyc(RWD_CYC + SYNC_LAT);
                  else cnt_q <= cyc(CAS_PULSE_CYC);
               end
               ST_WRITE: cnt_q <= cyc(WP_CYC);
               ST_REFRESH: begin
                  // hidden refresh: precharge first, then the row pulse
                  if (state_q == ST_RELEASE) cnt_q <= cyc(PRECHARGE_CYC + ROW_PULSE_CYC);
                  else cnt_q <= cyc(ROW_PULSE_CYC);
               end
               ST_PRECHARGE: cnt_q <= cyc(PRECHARGE_CYC);
               default: cnt_q <= '0;
            endcase
         end else if (!cnt_done) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // refresh scheduling and init count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_timer_q <= '0;
         ref_pending_q <= 1'b0;
         ref_row_q <= '0;
         init_cnt_q <= '0;
         init_done_q <= 1'b0;
      end else begin
         if (ref_tick) ref_timer_q <= cyc(REFRESH_GAP);
         else ref_timer_q <= ref_timer_q - 1'b1;
         if (state_q == ST_REFRESH && state_d == ST_PRECHARGE) begin
            ref_row_q <= ref_row_q + 1'b1;
            if (!init_done_q) begin
               init_cnt_q <= init_cnt_q + 1'b1;
               if (init_cnt_q == 4'(INIT_ROW_CYCLES - 1)) init_done_q <= 1'b1;
            end
         end
         if (ref_tick && init_done_q) ref_pending_q <= 1'b1;
         else if (state_q == ST_REFRESH && state_d == ST_PRECHARGE) ref_pending_q <= 1'b0;
      end
   end

   // powerup pause counter, separate so the main counter stays simple
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_q <= '0;
         pwr_done_q <= 1'b0;
      end else if (!pwr_done_q) begin
         pwr_q <= pwr_q + 1'b1;
         if (pwr_q == cyc(POWERUP_CYCLES)) pwr_done_q <= 1'b1;
      end
   end

   // request capture and pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_q <= DRC_OP_READ;
         addr_q <= '0;
         wdata_q <= 1'b0;
         hidden_q <= 1'b0;
         mem_addr <= '0;
         mem_ras_n <= 1'b1;
         mem_cas_n <= 1'b1;
         mem_write_n <= 1'b1;
         mem_din <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (start_req) begin
            op_q <= req_op;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            hidden_q <= (req_op == DRC_OP_READ);
            mem_addr <= req_addr[ADDR_W-1:HALF_W];
            mem_ras_n <= 1'b0;
            mem_din <= req_wdata;
            if (req_op == DRC_OP_WRITE) mem_write_n <= 1'b0;
         end
         if (start_ref) begin
            mem_addr <= ref_row_q;
            mem_ras_n <= 1'b0;
            mem_cas_n <= 1'b1;
            mem_write_n <= 1'b1;
         end
         if (state_q == ST_ROW && cnt_done) begin
            mem_addr <= addr_q[HALF_W-1:0];
            mem_cas_n <= 1'b0;
         end
         if (state_q == ST_WAIT && cnt_done && write_op) begin
            mem_write_n <= 1'b0;
            mem_din <= wdata_q;
         end
         if (state_q == ST_WAIT && cnt_done && op_q != DRC_OP_WRITE) begin
            rsp_rdata <= mem_dout_s;
         end
         if (state_q == ST_WAIT && cnt_done && op_q == DRC_OP_READ) rsp_valid <= 1'b1;
         if (state_q == ST_WRITE && cnt_done) rsp_valid <= 1'b1;
         if (state_q == ST_RELEASE) begin
            if (hide_ref) begin
               mem_ras_n <= 1'b1;
               mem_addr <= ref_row_q;
               hidden_q <= 1'b0;
            end else begin
               mem_ras_n <= 1'b1;
               mem_cas_n <= 1'b1;
            end
            mem_write_n <= 1'b1;
         end
         if (state_q == ST_REFRESH && cnt_q == CNT_W'(ROW_PULSE_CYC) && mem_ras_n) begin
            mem_ras_n <= 1'b0;
         end
         if (state_q == ST_REFRESH && cnt_done) begin
            mem_ras_n <= 1'b1;
            mem_cas_n <= 1'b1;
         end
      end
   end
endmodule : drc_ctrl
`default_nettype wire

// >>> dv/drc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module drc_ctrl_sva
   import drc_pkg::*;
#(
   parameter int unsigned REFRESH_GAP = REFRESH_GAP_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // user side
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic init_done,
   // memory pins
   input wire logic mem_ras_n,
   input wire logic mem_cas_n,
   input wire logic mem_write_n,
   input wire logic mem_din
);
   logic [7:0] ras_cnt_q, cas_cnt_q, falls_q;
   logic [15:0] gap_q;
   logic ras_p_q;
   wire ras_fall = ras_p_q & ~mem_ras_n;
   // cycles each strobe has been low, row cycles seen, cycles since a row cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ras_p_q <= 1'b1;
         ras_cnt_q <= 8'h00;
         cas_cnt_q <= 8'h00;
         falls_q <= 8'h00;
         gap_q <= 16'h0000;
      end else begin
         ras_p_q <= mem_ras_n;
         ras_cnt_q <= mem_ras_n ? 8'h00 : ras_cnt_q + 8'h01;
         cas_cnt_q <= mem_cas_n ? 8'h00 : cas_cnt_q + 8'h01;
         falls_q <= falls_q + {7'h00, ras_fall};
         gap_q <= ras_fall ? 16'h0000 : gap_q + 16'h0001;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ready_after_init_a: assert property (req_ready |-> init_done)
      else $error("request accepted before init");
   init_rows_a: assert property ($rose(init_done) |-> falls_q >= INIT_ROW_CYCLES)
      else $error("init done too early");
   write_window_a: assert property ($fell(mem_write_n) |-> mem_cas_n || $fell(mem_cas_n)
      || (cas_cnt_q >= CWD_CYC && ras_cnt_q >= RWD_CYC)) else $error("write in bad window");
   din_hold_a: assert property (($fell(mem_write_n) && !mem_cas_n)
      || ($fell(mem_cas_n) && !mem_write_n) |=> $stable(mem_din)) else $error("data in moved");
   cas_in_row_a: assert property ($fell(mem_cas_n) |-> !mem_ras_n && ras_cnt_q >= RCD_CYC)
      else $error("column strobe outside row");
   ras_pulse_a: assert property ($fell(mem_ras_n) |-> !mem_ras_n [*5])
      else $error("row pulse short");
   precharge_a: assert property ($rose(mem_ras_n) |-> mem_ras_n [*4])
      else $error("precharge short");
   refresh_gap_a: assert property (init_done |-> gap_q <= REFRESH_GAP + 32)
      else $error("refresh overdue");
   cover property ($rose(rsp_valid));
   cover property ($fell(mem_write_n) && !mem_cas_n);
   cover property ($fell(mem_ras_n) && !mem_cas_n);
endmodule : drc_ctrl_sva
bind drc_ctrl drc_ctrl_sva #(.REFRESH_GAP(REFRESH_GAP)) u_sva (.clk(clk), .rst(rst),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .init_done(init_done), .mem_ras_n(mem_ras_n),
   .mem_cas_n(mem_cas_n), .mem_write_n(mem_write_n), .mem_din(mem_din));
`default_nettype wire

// >>> dv/drc_dram_model.sv
`timescale 1ns/10ps
`default_nettype none
module drc_dram_model
   import drc_pkg::*;
(
   // memory pins
   input wire logic [HALF_W-1:0] mem_addr,
   input wire logic mem_ras_n,
   input wire logic mem_cas_n,
   input wire logic mem_write_n,
   input wire logic mem_din,
   output logic mem_dout
);
   logic cells [0:(1 << ADDR_W) - 1];
   logic [HALF_W-1:0] row_q;
   logic [ADDR_W-1:0] cell_q;
   logic q = 1'b0;
   logic drive = 1'b0;
   always @(negedge mem_ras_n) row_q = mem_addr;
   always @(negedge mem_cas_n) begin
      if (!mem_ras_n) begin
         cell_q = {row_q, mem_addr};
         if (!mem_write_n) begin
            cells[cell_q] = mem_din;
         end else begin
            q <= #(COLUMN_ACCESS_TIME_NS) cells[cell_q];
            drive <= #(COLUMN_ACCESS_TIME_NS) 1'b1;
         end
      end
   end
   always @(negedge mem_write_n) begin
      if (!mem_ras_n && !mem_cas_n) begin
         cells[cell_q] = mem_din;
      end
   end
   always @(posedge mem_cas_n) drive <= 1'b0;
   // released output shows the inverse of the last bit
   assign mem_dout = drive ? q : ~q;
endmodule : drc_dram_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import drc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_wdata = 1'b0;
   drc_op_t req_op = DRC_OP_READ;
   logic [ADDR_W-1:0] req_addr = 14'h0000;
   logic req_ready, rsp_valid, rsp_rdata, init_done, rd;
   logic mem_ras_n, mem_cas_n, mem_write_n, mem_din, mem_dout;
   logic cas_in_cyc = 1'b1;
   logic [HALF_W-1:0] mem_addr;
   logic [ADDR_W-1:0] addrs [4] = '{14'h0000, 14'h3FFF, 14'h2A55, 14'h2AD5};
   int bad_count = 0;
   int tests_run = 0;
   int ref_cnt = 0;
   int hid_cnt = 0;
   localparam int PAUSE_CYC = 20;
   logic took = 1'b0;
   always #20 clk = ~clk;
   // request taken at this edge, seen with the values that stood before it
   always @(posedge clk) took <= req_ready;
   drc_ctrl #(.POWERUP_CYCLES(PAUSE_CYC), .REFRESH_GAP(60)) dut (.clk(clk), .rst(rst),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
      .mem_addr(mem_addr), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
      .mem_write_n(mem_write_n), .mem_din(mem_din), .mem_dout(mem_dout));
   drc_dram_model model (.mem_addr(mem_addr), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
      .mem_write_n(mem_write_n), .mem_din(mem_din), .mem_dout(mem_dout));
   // classify row cycles: row-only refresh or hidden refresh
   always @(negedge mem_ras_n) begin
      if (!mem_cas_n) hid_cnt++;
      cas_in_cyc = !mem_cas_n;
   end
   always @(negedge mem_cas_n) cas_in_cyc = 1'b1;
   always @(posedge mem_ras_n) if (!cas_in_cyc) ref_cnt++;
   task automatic fail(input string m);
      $display("wrong value at %0t: %s", $time, m);
      bad_count++;
   endtask : fail
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic timeout(input string m);
      fail(m);
      end_of_test();
   endtask : timeout
   task automatic chk_bit(input logic got, input logic exp, input string m);
      tests_run++;
      if (got !== exp) fail(m);
   endtask : chk_bit
   task automatic chk_min(input int got, input int lo, input string m);
      tests_run++;
      if (got < lo) fail(m);
   endtask : chk_min
   task automatic do_op(input drc_op_t op, input logic [ADDR_W-1:0] a, input logic wd);
      int i;
      @(negedge clk);
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = wd;
      @(negedge clk);
      for (i = 0; i < 200 && took !== 1'b1; i++) @(negedge clk);
      if (i == 200) timeout("not accepted");
      req_valid = 1'b0;
      for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge clk);
      if (i == 100) timeout("no answer");
      rd = rsp_rdata;
   endtask : do_op
   task automatic t_init();
      int i;
      for (i = 0; i < 2000 && mem_ras_n === 1'b1; i++) @(negedge clk);
      chk_min(i, PAUSE_CYC, "power-up pause");
      for (i = 0; i < 2000 && init_done !== 1'b1; i++) @(negedge clk);
      if (i == 2000) timeout("no init");
      chk_min(ref_cnt, INIT_ROW_CYCLES, "init rows");
      $display("test init done");
   endtask : t_init
   task automatic t_write_read();
      int i;
      for (i = 0; i < 4; i++) do_op(DRC_OP_WRITE, addrs[i], ~i[0]);
      for (i = 0; i < 4; i++) begin
         do_op(DRC_OP_READ, addrs[i], 1'b0);
         chk_bit(rd, ~i[0], "read back");
      end
      $display("test write read done");
   endtask : t_write_read
   task automatic t_rmw();
      do_op(DRC_OP_RMW, addrs[1], 1'b1);
      chk_bit(rd, 1'b0, "old bit");
      do_op(DRC_OP_READ, addrs[1], 1'b0);
      chk_bit(rd, 1'b1, "new bit");
      $display("test rmw done");
   endtask : t_rmw
   task automatic t_refresh();
      int n;
      n = ref_cnt;
      repeat (200) @(negedge clk);
      chk_min(ref_cnt - n, 3, "idle refresh");
      do_op(DRC_OP_READ, addrs[2], 1'b0);
      chk_bit(rd, 1'b1, "kept");
      $display("test refresh done");
   endtask : t_refresh
   task automatic t_hidden();
      int i;
      int h;
      h = hid_cnt;
      for (i = 0; i < 16; i++) begin
         do_op(DRC_OP_READ, addrs[2 + i % 2], 1'b0);
         chk_bit(rd, ~i[0], "reads");
      end
      chk_min(hid_cnt - h, 1, "hidden refresh");
      $display("test hidden done");
   endtask : t_hidden
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_init();
      t_write_read();
      t_rmw();
      t_refresh();
      t_hidden();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
